// ---- design/ssd_regs.svh ----
/*
  register offsets, field positions, reset values and timing counts
  for the secure serial data support block.
  assumes a 100 MHz system clock; included by bare name.
*/
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH
////////////////////////////////////////////////////////////////////////
// output latches (write), read buffers (read)
`define SSD_L_CTRL     4'h0
`define SSD_L_HYB      4'h1
`define SSD_L_KEYPOLL  4'h2
`define SSD_L_TX_OUT   4'h3
`define SSD_L_RX_OUT   4'h4
`define SSD_L_KR       4'h5
`define SSD_L_GPO      4'h6
`define SSD_B_TX_BYTE  4'h0
`define SSD_B_RX_BYTE  4'h1
`define SSD_B_TX_LOCK  4'h2
`define SSD_B_RX_LOCK  4'h3
`define SSD_B_KEYSTAT  4'h4
`define SSD_B_STATUS   4'h5
`define SSD_B_CTRL     4'h6
`define SSD_B_HYB      4'h7
////////////////////////////////////////////////////////////////////////
// control latch fields
`define SSD_CTRL_ALERT    0
`define SSD_CTRL_ALIGN    1
`define SSD_CTRL_FIX_TX   2
`define SSD_CTRL_FIX_RX   3
`define SSD_CTRL_DIV10    4
// hybrid latch fields
`define SSD_HYB_SEL_LSB   0
`define SSD_HYB_WE        3
`define SSD_HYB_KEY       4
// key poll latch fields
`define SSD_POLL_RT       0
`define SSD_POLL_PTT      1
// key reset latch trigger bits
`define SSD_KR_TRIG_A     0
`define SSD_KR_TRIG_B     1
`define SSD_RST_LATCH     8'h00
////////////////////////////////////////////////////////////////////////
// timing
`define SSD_CLK_KHZ       100000
`define SSD_CRYSTAL_REFERENCE_KHZ      3072
`define SSD_KR_US         10000
`define SSD_LOCK_WIN      8'h04
`define SSD_HALF_1K       1536
`define SSD_DIV9          9
`define SSD_DIV10         10
`endif

// ---- design/ssd_pkg.sv ----
/*
  types of the secure serial data support block.
  assumes ssd_regs.svh for all numeric constants.
*/
package ssd_pkg;
  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ssd_bus_req_t;
  // per-hybrid routed lines
  typedef struct packed {
    logic [7:0] we;
    logic [7:0] key;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
  } ssd_hyb_out_t;
  // one clock recovery / serial path
  typedef struct packed {
    logic [7:0] phase;
    logic       clk;
    logic       dprev;
    logic [7:0] lock;
    logic [7:0] sipo;
    logic [2:0] bitcnt;
    logic [7:0] byte_in;
    logic       irq;
    logic [7:0] piso;
  } ssd_path_t;
  typedef struct packed {
    logic [16:0]    xacc;
    logic [11:0]    tone_cnt;
    logic [11:0]    k1_cnt;
    logic           k1_sq;
    logic [3:0]     fcnt;
    logic           fclk;
    logic [7:0][7:0] latch;
    logic [7:0]     rdata;
    logic [17:0]    s1;
    logic [17:0]    s2;
    logic [17:0]    s3;
    logic [17:0]    filt;
    ssd_path_t [1:0] path;
    logic [19:0]    kr_a;
    logic [19:0]    kr_b;
    logic           kr_both;
    logic           krst;
  } ssd_state_t;
endpackage

// ---- design/ssd_core.sv ----
/*
  secure serial data support block: crystal-derived timebase, two
  clock recovery paths with lock counts, byte assembly and serial
  output, tones, filter clock, guarded key reset and hybrid routing.
  assumes a 100 MHz sys_clk_i, synchronous active-high rst_i and a
  register master that reads bytes before the next bit arrives.
*/
// Function
// - secure clocks come from a 3.072 MHz crystal reference timebase
// - seven byte output latches and eight byte read buffers for software
// - read buffers also sample hybrid key-status lines
// - 12 kHz clock per path shifts phase so falling edges meet data
// - each path may run a fixed free-running 12 kHz clock
// - lock count from data transitions versus falling edge, readable
// - eight received bits assemble a byte and raise the path interrupt
// - interrupt is high one bit time, every eight bit times
// - outgoing byte loads on a rising edge while interrupt is high
// - loaded byte shifts out msb first, over the load edge and the next seven rising edges
// - 750 Hz square wave gated onto alert tone by software
// - filter clock is crystal divided by nine or ten
// - key reset only when two timers are triggered together
// - key reset is active high, between 9.3 and 10.67 ms wide
// - multiplexers route we, key, rx, ciphertext and tx data lines
// - three select lines choose the key loader switch channel
// - 1 kHz square wave can drive the coded modulation output
// - recovered clocks run internal logic and drive external pins
`timescale 1ns/1ps
`include "ssd_regs.svh"

module ssd_core #(
  parameter int unsigned KR_CYCLES = (`SSD_KR_US * `SSD_CLK_KHZ) / 1000
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire ssd_pkg::ssd_bus_req_t bus_i,
  output logic [7:0]                 rdata_o,
  input  wire logic                  tx_data_i,
  input  wire logic                  rx_data_i,
  input  wire logic [7:0]            hyb_key_stat_i,
  input  wire logic [7:0]            hyb_tx_ciphertext_i,
  output logic                       tx_clk_o,
  output logic                       rx_clk_o,
  output logic                       tx_irq_o,
  output logic                       rx_irq_o,
  output ssd_pkg::ssd_hyb_out_t      hyb_o,
  output logic                       tx_ciphertext_o,
  output logic                       coded_mod_o,
  output logic                       alert_tone_o,
  output logic                       filter_clk_o,
  output logic                       key_reset_o,
  output logic [2:0]                 key_loader_line_sel_o,
  output logic                       hyb_rt_o,
  output logic                       hyb_ptt_o,
  output logic [7:0]                 gpo_o
);

  localparam logic [16:0] XMOD  = 17'(`SSD_CLK_KHZ);
  localparam logic [16:0] XSTEP = 17'(`SSD_CRYSTAL_REFERENCE_KHZ);
  localparam logic [19:0] KR_LD = 20'(KR_CYCLES);
  localparam logic [11:0] K1_HALF = 12'(`SSD_HALF_1K);

  ssd_pkg::ssd_state_t st_q;
  ssd_pkg::ssd_state_t st_d;

  //////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [16:0] acc_sum;
    logic        xtick;
    logic [17:0] raw;
    logic [3:0]  div;
    logic        din;
    logic        fixed;
    logic        trans;
    logic [7:0]  nph;
    logic        rise;
    logic [7:0]  wb;
    st_d    = st_q;
    acc_sum = 17'h0;
    xtick   = 1'b0;
    raw     = 18'h0;
    div     = 4'h0;
    din     = 1'b0;
    fixed   = 1'b0;
    trans   = 1'b0;
    nph     = 8'h0;
    rise    = 1'b0;
    wb      = 8'h0;

    // exact 3.072 MHz tick from the 100 MHz clock, no drift
    acc_sum = st_q.xacc + XSTEP;
    if (acc_sum >= XMOD) begin
      xtick     = 1'b1;
      st_d.xacc = acc_sum - XMOD;
    end else begin
      st_d.xacc = acc_sum;
    end

    // three-stage pin sync; a change counts once stages two and three agree
    raw = {hyb_tx_ciphertext_i, hyb_key_stat_i, rx_data_i, tx_data_i};
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < 18; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.filt[i] = st_q.s3[i];
      end
    end

    // tones: 750 Hz is crystal/4096, 1 kHz is crystal/3072
    if (xtick) begin
      st_d.tone_cnt = st_q.tone_cnt + 12'h001;
      if (st_q.k1_cnt == K1_HALF - 12'h001) begin
        st_d.k1_cnt = 12'h000;
        st_d.k1_sq  = ~st_q.k1_sq;
      end else begin
        st_d.k1_cnt = st_q.k1_cnt + 12'h001;
      end
    end

    // filter clock: crystal divided by nine or ten
    div = st_q.latch[`SSD_L_CTRL][`SSD_CTRL_DIV10] ? 4'(`SSD_DIV10)
                                                 : 4'(`SSD_DIV9);
    if (xtick) begin
      if (st_q.fcnt >= div - 4'h1) begin
        st_d.fcnt = 4'h0;
      end else begin
        st_d.fcnt = st_q.fcnt + 4'h1;
      end
      st_d.fclk = (st_d.fcnt < (div >> 1));
    end

    // clock recovery and serial paths, 0 = transmit, 1 = receive
    for (int p = 0; p < 2; p++) begin
      din   = st_q.filt[p];
      fixed = st_q.latch[`SSD_L_CTRL][`SSD_CTRL_FIX_TX + p];
      trans = din ^ st_q.path[p].dprev;
      st_d.path[p].dprev = din;
      // phase runs 256 crystal ticks per bit; falling edge at wrap to 0
      nph = st_q.path[p].phase + {7'h00, xtick};
      if (trans && !fixed) begin
        // falling edge came early: hold back; late: pull forward
        if (st_q.path[p].phase[7]) begin
          nph = nph + 8'h01;
        end else if (st_q.path[p].phase != 8'h00) begin
          nph = nph - 8'h01;
        end
      end
      st_d.path[p].phase = nph;
      // lock quality: saturating up in the window, down outside it
      if (trans) begin
        if (st_q.path[p].phase < `SSD_LOCK_WIN ||
            st_q.path[p].phase > 8'hff - `SSD_LOCK_WIN) begin
          if (st_q.path[p].lock != 8'hff) begin
            st_d.path[p].lock = st_q.path[p].lock + 8'h01;
          end
        end else if (st_q.path[p].lock != 8'h00) begin
          st_d.path[p].lock = st_q.path[p].lock - 8'h01;
        end
      end
      st_d.path[p].clk = nph[7];
      rise = nph[7] & ~st_q.path[p].clk;
      if (rise) begin
        // sample mid-bit, half a period after the falling edge
        st_d.path[p].sipo   = {st_q.path[p].sipo[6:0], din};
        st_d.path[p].bitcnt = st_q.path[p].bitcnt + 3'h1;
        if (st_q.path[p].irq) begin
          st_d.path[p].irq  = 1'b0;
          st_d.path[p].piso = st_q.latch[`SSD_L_TX_OUT + p];
        end else begin
          st_d.path[p].piso = {st_q.path[p].piso[6:0], 1'b0};
        end
        if (st_q.path[p].bitcnt == 3'h7) begin
          st_d.path[p].byte_in = {st_q.path[p].sipo[6:0], din};
          st_d.path[p].irq     = 1'b1;
        end
      end
    end

    // register writes to the seven output latches
    if (bus_i.wr && bus_i.addr <= `SSD_L_GPO) begin
      st_d.latch[bus_i.addr[2:0]] = bus_i.wdata;
    end

    // key reset: both one-shots must start in the same write
    wb = bus_i.wdata;
    if (st_q.kr_a != 20'h0) begin
      st_d.kr_a = st_q.kr_a - 20'h1;
    end
    if (st_q.kr_b != 20'h0) begin
      st_d.kr_b = st_q.kr_b - 20'h1;
    end
    if (bus_i.wr && bus_i.addr == `SSD_L_KR) begin
      if (wb[`SSD_KR_TRIG_A]) begin
        st_d.kr_a = KR_LD;
      end
      if (wb[`SSD_KR_TRIG_B]) begin
        st_d.kr_b = KR_LD;
      end
      // a retrigger of only one timer cancels the pairing
      st_d.kr_both = wb[`SSD_KR_TRIG_A] & wb[`SSD_KR_TRIG_B];
    end
    st_d.krst = st_d.kr_both & (st_d.kr_a != 20'h0) &
                (st_d.kr_b != 20'h0);

    // read buffers, data valid in the cycle after the strobe only
    st_d.rdata = 8'h00;
    if (bus_i.rd) begin
      if (bus_i.addr == `SSD_B_TX_BYTE) begin
        st_d.rdata = st_q.path[0].byte_in;
      end else if (bus_i.addr == `SSD_B_RX_BYTE) begin
        st_d.rdata = st_q.path[1].byte_in;
      end else if (bus_i.addr == `SSD_B_TX_LOCK) begin
        st_d.rdata = st_q.path[0].lock;
      end else if (bus_i.addr == `SSD_B_RX_LOCK) begin
        st_d.rdata = st_q.path[1].lock;
      end else if (bus_i.addr == `SSD_B_KEYSTAT) begin
        st_d.rdata = st_q.filt[9:2];
      end else if (bus_i.addr == `SSD_B_STATUS) begin
        st_d.rdata = {3'h0, st_q.krst, st_q.path[1].irq,
                      st_q.path[0].irq, st_q.path[1].clk,
                      st_q.path[0].clk};
      end else if (bus_i.addr == `SSD_B_CTRL) begin
        st_d.rdata = st_q.latch[`SSD_L_CTRL];
      end else if (bus_i.addr == `SSD_B_HYB) begin
        st_d.rdata = st_q.latch[`SSD_L_HYB];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register; reset gives tones off, tracking, key reset low
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops or the latch-selected routing
  logic [2:0] hsel;
  assign hsel = st_q.latch[`SSD_L_HYB][2:0];

  assign rdata_o      = st_q.rdata;
  assign tx_clk_o     = st_q.path[0].clk;
  assign rx_clk_o     = st_q.path[1].clk;
  assign tx_irq_o     = st_q.path[0].irq;
  assign rx_irq_o     = st_q.path[1].irq;
  assign filter_clk_o = st_q.fclk;
  assign key_reset_o  = st_q.krst;
  assign gpo_o        = st_q.latch[`SSD_L_GPO];
  assign key_loader_line_sel_o = hsel;
  assign hyb_rt_o  = st_q.latch[`SSD_L_KEYPOLL][`SSD_POLL_RT];
  assign hyb_ptt_o = st_q.latch[`SSD_L_KEYPOLL][`SSD_POLL_PTT];

  // alert tone is bit 11 of the crystal tick count, crystal/4096
  assign alert_tone_o = st_q.latch[`SSD_L_CTRL][`SSD_CTRL_ALERT] &
                        st_q.tone_cnt[11];

  // hybrid routing: one selected hybrid gets every routed line
  assign hyb_o.we      = 8'(st_q.latch[`SSD_L_HYB][`SSD_HYB_WE])
                         << hsel;
  assign hyb_o.key     = 8'(st_q.latch[`SSD_L_HYB][`SSD_HYB_KEY])
                         << hsel;
  assign hyb_o.tx_data = 8'(st_q.path[0].piso[7]) << hsel;
  assign hyb_o.rx_data = 8'(st_q.path[1].piso[7]) << hsel;
  assign tx_ciphertext_o = st_q.filt[10 + 32'(hsel)];

  // alignment replaces ciphertext on the modulation output
  assign coded_mod_o = st_q.latch[`SSD_L_CTRL][`SSD_CTRL_ALIGN] ?
                       st_q.k1_sq : tx_ciphertext_o;

endmodule // ssd_core

// ---- tb/ssd_core_checker.sv ----
/*
  port-level assertions for ssd_core.
  assumes the bind at the foot and KR_CYCLES handed on from the instance.
*/
`timescale 1ns/1ps
`include "ssd_regs.svh"
module ssd_core_checker #(
  parameter int unsigned KR_CYCLES = 50
) (
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  input wire ssd_pkg::ssd_bus_req_t bus_i,
  input wire logic [7:0]            rdata_o,
  input wire ssd_pkg::ssd_hyb_out_t hyb_o,
  input wire logic                  tx_ciphertext_o,
  input wire logic                  coded_mod_o,
  input wire logic                  alert_tone_o,
  input wire logic                  key_reset_o,
  input wire logic [2:0]            key_loader_line_sel_o,
  input wire logic                  tx_irq_o,
  input wire logic                  rx_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0]  ctrl_q;
  logic [7:0]  hyb_q;
  logic [13:0] rxw_q;
  logic [13:0] txw_q;
  logic [19:0] krw_q;
  logic        kr_req;
  logic        kr_any;
  ////////////////////////////////////////////////////////////////////
  // shadows of the latches rebuilt from the bus, pulse widths counted from the outputs
  assign kr_any = bus_i.wr && bus_i.addr == `SSD_L_KR;
  assign kr_req = kr_any && bus_i.wdata[1:0] == 2'h3;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_q <= 8'h00;
      hyb_q  <= 8'h00;
    end else begin
      if (bus_i.wr && bus_i.addr == `SSD_L_CTRL) ctrl_q <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == `SSD_L_HYB) hyb_q <= bus_i.wdata;
    end
    rxw_q <= rx_irq_o ? rxw_q + 14'h0001 : 14'h0000;
    txw_q <= tx_irq_o ? txw_q + 14'h0001 : 14'h0000;
    krw_q <= key_reset_o ? krw_q + 20'h00001 : 20'h00000;
  end
  ////////////////////////////////////////////////////////////////////
  // one-hot routing pattern; a latch change needs two quiet cycles
  sequence s_kr_trig;
    kr_req;
  endsequence
  a_read_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_read_unmapped: assert property (bus_i.rd && bus_i.addr[3] |=>
    rdata_o == 8'h00) else $error("unmapped read not zero");
  a_read_ctrl: assert property (bus_i.rd && bus_i.addr == `SSD_B_CTRL |=>
    rdata_o == $past(ctrl_q)) else $error("control readback wrong");
  a_alert_off: assert property (!ctrl_q[0] && ctrl_q == $past(ctrl_q, 2)
    |-> !alert_tone_o) else $error("alert tone while gated off");
  a_mod_follow: assert property (!ctrl_q[1] && ctrl_q == $past(ctrl_q, 2)
    |-> coded_mod_o == tx_ciphertext_o) else $error("coded mod wrong");
  a_hyb_route: assert property ($stable(hyb_q) && hyb_q == $past(hyb_q, 2)
    |-> key_loader_line_sel_o == hyb_q[2:0] && hyb_o.key ==
    (hyb_q[4] ? 8'h01 << hyb_q[2:0] : 8'h00)) else $error("routing wrong");
  a_kr_start: assert property (s_kr_trig |-> ##[1:2] key_reset_o)
    else $error("key reset did not start");
  a_kr_guard: assert property ($rose(key_reset_o) |-> $past(kr_req, 1) ||
    $past(kr_req, 2)) else $error("key reset without both triggers");
  a_kr_width: assert property ($fell(key_reset_o) && !$past(kr_any, 1) &&
    !$past(kr_any, 2) |-> krw_q >= KR_CYCLES * 93 / 100 - 1 &&
    krw_q <= KR_CYCLES + 1) else $error("key reset width wrong");
  a_rx_width: assert property ($fell(rx_irq_o) |-> rxw_q >= 14'h206c &&
    rxw_q <= 14'h20b2) else $error("rx interrupt width wrong");
  a_tx_width: assert property ($fell(tx_irq_o) |-> txw_q >= 14'h206c &&
    txw_q <= 14'h20b2) else $error("tx interrupt width wrong");
endmodule // ssd_core_checker
bind ssd_core ssd_core_checker #(.KR_CYCLES(KR_CYCLES)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .hyb_o(hyb_o), .tx_ciphertext_o(tx_ciphertext_o),
  .coded_mod_o(coded_mod_o), .alert_tone_o(alert_tone_o),
  .key_reset_o(key_reset_o), .key_loader_line_sel_o(key_loader_line_sel_o),
  .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));

// ---- tb/ssd_far_end.sv ----
/*
  far-end model: a hybrid clocked by the recovered clocks, sending
  alternating bits on both paths. assumes clocks stay low in reset.
*/
`timescale 1ns/1ps
module ssd_far_end (
  input  wire logic tx_clk_i,
  input  wire logic rx_clk_i,
  output logic      tx_data_o,
  output logic      rx_data_o
);
  ////////////////////////////////////////////////////////////////////
  // data change on the falling edge, so locked edges meet transitions
  initial begin
    tx_data_o = 1'b0;
    rx_data_o = 1'b0;
  end
  always @(negedge tx_clk_i) tx_data_o <= ~tx_data_o;
  always @(negedge rx_clk_i) rx_data_o <= ~rx_data_o;
endmodule // ssd_far_end

// ---- tb/ssd_core_tb.sv ----
/*
  testbench of ssd_core: register tasks and directed tests.
  assumes ssd_far_end on the serial side and the bound checker.
*/
`timescale 1ns/1ps
`include "ssd_regs.svh"
module ssd_core_tb;
  localparam int unsigned KR = 50;
  logic sys_clk_i, rst_i, tx_d, rx_d, tx_clk, rx_clk, tx_irq, rx_irq;
  logic txc, cmod, alert, fclk, krst, rt, ptt;
  logic [7:0] rdata, kstat, ciph, gpo, b;
  logic [3:0] bits;
  logic [2:0] sel;
  ssd_pkg::ssd_bus_req_t bus;
  ssd_pkg::ssd_hyb_out_t hyb;
  int fails, comparisons, n, w;
  ////////////////////////////////////////////////////////////////////
  ssd_core #(.KR_CYCLES(KR)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .tx_data_i(tx_d), .rx_data_i(rx_d), .hyb_key_stat_i(kstat),
    .hyb_tx_ciphertext_i(ciph), .tx_clk_o(tx_clk), .rx_clk_o(rx_clk),
    .tx_irq_o(tx_irq), .rx_irq_o(rx_irq), .hyb_o(hyb),
    .tx_ciphertext_o(txc), .coded_mod_o(cmod), .alert_tone_o(alert),
    .filter_clk_o(fclk), .key_reset_o(krst), .key_loader_line_sel_o(sel),
    .hyb_rt_o(rt), .hyb_ptt_o(ptt), .gpo_o(gpo));
  ssd_far_end far (.tx_clk_i(tx_clk), .rx_clk_i(rx_clk),
    .tx_data_o(tx_d), .rx_data_o(rx_d));
  ////////////////////////////////////////////////////////////////////
  // result checks, verdict and bus cycles
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkrng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      fails++;
      $display("ERROR %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_i);
    bus.rd <= 1'b0;
    #1 b = rdata;
    chk8(b, exp);
  endtask
  // edge waits are bounded; running out ends the run as a mismatch
  function automatic logic pick(input int s);
    case (s)
      0: return fclk;
      1: return rx_irq;
      2: return rx_clk;
      default: return krst;
    endcase
  endfunction
  task automatic wait_edge(input int s, input logic lvl, input int bound,
                           output int cnt);
    logic prev;
    cnt = 0;
    prev = pick(s);
    forever begin
      @(posedge sys_clk_i);
      #1;
      cnt++;
      if (pick(s) === lvl && prev !== lvl) break;
      prev = pick(s);
      if (cnt >= bound) begin
        fails++;
        $display("ERROR %0t wait ran out", $time);
        conclude();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // main sequence; latches are set early so serial bytes use them
  initial begin
    fails = 0;
    comparisons = 0;
    rst_i = 1'b1;
    bus = '0;
    kstat = 8'h00;
    ciph = 8'h00;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdchk(`SSD_B_CTRL, 8'h00);
    rdchk(`SSD_B_HYB, 8'h00);
    chk8({6'h00, krst, alert}, 8'h00);
    rdchk(4'hf, 8'h00);
    $display("test reset done");
    wr(`SSD_L_CTRL, 8'h01);
    rdchk(`SSD_B_CTRL, 8'h01);
    wr(`SSD_L_HYB, 8'h1d);
    rdchk(`SSD_B_HYB, 8'h1d);
    chk8(hyb.key, 8'h20);
    chk8(hyb.we, 8'h20);
    chk8({5'h00, sel}, 8'h05);
    wr(`SSD_L_KEYPOLL, 8'h03);
    wr(`SSD_L_GPO, 8'ha5);
    wr(`SSD_L_TX_OUT, 8'hc3);
    wr(`SSD_L_RX_OUT, 8'hc3);
    chk8({6'h00, ptt, rt}, 8'h03);
    chk8(gpo, 8'ha5);
    @(posedge sys_clk_i);
    kstat <= 8'h96;
    ciph <= 8'h20;
    repeat (6) @(posedge sys_clk_i);
    rdchk(`SSD_B_KEYSTAT, 8'h96);
    chk8({6'h00, cmod, txc}, 8'h03);
    // alignment on early: the 1 kHz square is still low here
    wr(`SSD_L_CTRL, 8'h02);
    rdchk(`SSD_B_CTRL, 8'h02);
    chk8({6'h00, cmod, txc}, 8'h01);
    $display("test latches done");
    for (int i = 9; i <= 10; i++) begin
      wr(`SSD_L_CTRL, i == 10 ? 8'h10 : 8'h00);
      wait_edge(0, 1'b1, 2000, n);
      w = 0;
      repeat (8) begin
        wait_edge(0, 1'b1, 400, n);
        w += n;
      end
      chkrng(w, 8 * i * 100000 / 3072 - 40, 8 * i * 100000 / 3072 + 40);
    end
    $display("test filter clock done");
    wr(`SSD_L_KR, 8'h01);
    n = 0;
    repeat (60) begin
      @(posedge sys_clk_i);
      n += int'(krst === 1'b1);
    end
    chkrng(n, 0, 0);
    wr(`SSD_L_KR, 8'h00);
    wr(`SSD_L_KR, 8'h03);
    wait_edge(3, 1'b1, 5, n);
    wait_edge(3, 1'b0, 200, w);
    chkrng(w, KR * 93 / 100, KR * 1067 / 1000 + 1);
    wr(`SSD_L_KR, 8'h00);
    $display("test key reset done");
    wait_edge(1, 1'b1, 90000, n);
    wait_edge(1, 1'b0, 9000, w);
    chkrng(w, 8300, 8370);
    // first byte after reset: bits 0,1,0,1.. msb first; eight locked edges
    rdchk(`SSD_B_RX_BYTE, 8'h55);
    chk8(b ^ {b[0], b[7:1]}, 8'hff);
    rdchk(`SSD_B_RX_LOCK, 8'h08);
    chkrng(int'(b), 4, 255);
    rdchk(`SSD_B_TX_BYTE, 8'h55);
    rdchk(`SSD_B_TX_LOCK, 8'h08);
    for (int i = 3; i >= 0; i--) begin
      wait_edge(2, 1'b0, 9000, n);
      bits[i] = hyb.rx_data[5];
    end
    chk8({4'h0, bits}, 8'h0c);
    $display("test serial done");
    conclude();
  end
endmodule // ssd_core_tb
